/* File: hdl/fsiu_pkg.sv */
package fsiu_pkg;

  // ----------------------------------------------------------------
  // widths, source count and stack depth
  // ----------------------------------------------------------------
  localparam int PC_W   = 12;
  localparam int PTR_W  = 3;
  localparam int BANK_W = 4;
  localparam int PSW_W  = 5;
  localparam int RFA_W  = 7;
  localparam int NSRC   = 4;
  localparam int ISK_D  = 3;

  // ----------------------------------------------------------------
  // register file locations and fields
  // ----------------------------------------------------------------
  localparam logic [RFA_W-1:0] SERIAL_REQ_OFS = 7'h3B;
  localparam logic [RFA_W-1:0] TIMER_REQ_OFS  = 7'h3C;
  localparam logic [RFA_W-1:0] WATCH_REQ_OFS  = 7'h3D;
  localparam logic [RFA_W-1:0] EXT_REQ_OFS    = 7'h3E;
  localparam logic [RFA_W-1:0] ENABLE_OFS     = 7'h2F;
  localparam logic [RFA_W-1:0] PIN_LVL_OFS    = 7'h0F;
  localparam logic [RFA_W-1:0] WATCH_SEL_OFS  = 7'h03;
  localparam int REQ_BIT       = 3;
  localparam int PIN_LVL_BIT   = 0;
  localparam int WATCH_SEL_BIT = 2;

  // source index equals priority order, index 0 highest
  localparam int SRC_TIMER  = 0;
  localparam int SRC_EXT    = 1;
  localparam int SRC_WATCH  = 2;
  localparam int SRC_SERIAL = 3;

  // ----------------------------------------------------------------
  // vectors and reset values
  // ----------------------------------------------------------------
  localparam logic [PC_W-1:0] VEC_TIMER  = 12'h004;
  localparam logic [PC_W-1:0] VEC_EXT    = 12'h003;
  localparam logic [PC_W-1:0] VEC_WATCH  = 12'h002;
  localparam logic [PC_W-1:0] VEC_SERIAL = 12'h001;
  localparam logic [PTR_W-1:0] PTR_RST   = 3'h5;
  localparam logic [3:0]      NIB_RST    = 4'h0;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic             cyc_end;
    logic             table_read_op;
    logic             enable_interrupts_op;
    logic             mask_all_op;
    logic             return_from_handler_op;
    logic             branch_op;
    logic [PC_W-1:0]  branch_target;
    logic [PC_W-1:0]  pc;
    logic [BANK_W-1:0] bank;
    logic [PSW_W-1:0] psw;
  } fsiu_cpu_t;

  typedef struct packed {
    logic             load;
    logic [PC_W-1:0]  pc;
    logic [BANK_W-1:0] bank;
    logic             psw_load;
    logic [PSW_W-1:0] psw;
    logic             bank_load;
    logic             accept;
  } fsiu_ctl_t;

  typedef struct packed {
    logic             wr;
    logic             rd;
    logic [RFA_W-1:0] addr;
    logic [3:0]       wdata;
  } fsiu_rf_t;

endpackage

/* File: hdl/fsiu_prio.sv */
`timescale 1ns/1ns
`default_nettype none
module fsiu_prio
  import fsiu_pkg::*;
(
  input  wire logic [NSRC-1:0] eligible,
  output logic                 any,
  output logic [NSRC-1:0]      grant
);
  logic [NSRC:0] blocked;
  assign blocked[0] = 1'b0;
  // lowest index wins, one grant at most
  genvar g;
  generate
    for (g = 0; g < NSRC; g++)
    begin : g_chain
      assign grant[g]     = eligible[g] & ~blocked[g];
      assign blocked[g+1] = blocked[g] | eligible[g];
    end
  endgenerate
  assign any = blocked[NSRC];
endmodule
`default_nettype wire

/* File: hdl/fsiu_top.sv */
// How it works
// - four sources: timer 0004H, pin edge 0003H, watch 0002H, serial 0001H
// - simultaneous pending requests accepted highest priority first, priority 1 highest
// - mask-all and servicing block acceptance of any other interrupt
// - after enable-interrupts, no acceptance until the next instruction completes
// - request flag set by its source, cleared by hardware on service
// - each request has its own enable flag, 1 allows, 0 blocks
// - enable-interrupts sets master enable, mask-all clears it, never readable
// - reset clears master enable, all interrupts disabled
// - rising edge on external pin sets external request flag
// - timer match signal sets the timer request flag
// - watch timer request sets watch flag; interval select at 03H bit 2
// - end of serial transfer sets the serial request flag
// - readable pin-level flag mirrors external interrupt pin level
// - software writes request flags: 1 raises, 0 cancels
// - request and enable both set: service at end of that instruction cycle
// - during a table read, service waits until end of its second cycle
// - disabled source keeps its request pending until enabled
// - lower priority waits until higher priority processing finished
// - accept: stack pointer minus one, store pc or branch target there
// - accept: push bank and status flags on three-level stack, load vector
// - whole acceptance sequence done within one instruction cycle
// - return restores status flags, reloads pc from stack, stack pointer plus one
`timescale 1ns/1ns
`default_nettype none
module fsiu_top
  import fsiu_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                clk_en,
  input  wire fsiu_pkg::fsiu_cpu_t cpu,
  input  wire fsiu_pkg::fsiu_rf_t  rf,
  input  wire logic                ext_pin,
  input  wire logic                timer_match,
  input  wire logic                watch_req,
  input  wire logic                serial_done,
  output logic [3:0]               rf_rdata,
  output fsiu_pkg::fsiu_ctl_t      ctl,
  output logic                     watch_interval_select
);
  import fsiu_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_RUN, ST_TBL2} fsiu_seq_t;

  fsiu_seq_t         seq_r;
  logic [NSRC-1:0]   req_r;
  logic [NSRC-1:0]   ena_r;
  logic              master_enable_flag_r;
  logic              enable_op_dly_r;
  logic              pin_d_r;
  logic              pin_lvl_r;
  logic [PTR_W-1:0]  stack_pointer_r;
  logic [PC_W-1:0]   address_stack [0:(1<<PTR_W)-1];
  logic [BANK_W+PSW_W-1:0] handler_status_stack [0:ISK_D-1];
  logic              wsel_r;
  logic [3:0]        rdata_nxt;
  fsiu_ctl_t         ctl_nxt;
  logic [NSRC-1:0]   src_set;
  logic [NSRC-1:0]   sw_wr;
  logic [NSRC-1:0]   eligible;
  logic [NSRC-1:0]   grant;
  logic              any_req;
  logic              boundary;
  logic              accept;
  logic              ret;
  logic [PC_W-1:0]   vec;
  logic [PTR_W-1:0]  stack_ptr_dec;

  // ----------------------------------------------------------------
  // source events and request flags
  // ----------------------------------------------------------------
  assign src_set[SRC_TIMER]  = timer_match;
  assign src_set[SRC_EXT]    = ext_pin & ~pin_d_r;
  assign src_set[SRC_WATCH]  = watch_req;
  assign src_set[SRC_SERIAL] = serial_done;

  assign sw_wr[SRC_TIMER]  = rf.wr && rf.addr == TIMER_REQ_OFS;
  assign sw_wr[SRC_EXT]    = rf.wr && rf.addr == EXT_REQ_OFS;
  assign sw_wr[SRC_WATCH]  = rf.wr && rf.addr == WATCH_REQ_OFS;
  assign sw_wr[SRC_SERIAL] = rf.wr && rf.addr == SERIAL_REQ_OFS;

  // pin sampling for edge detect and level flag
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_d_r   <= 1'b0;
      pin_lvl_r <= 1'b0;
    end
    else if (clk_en)
    begin
      pin_d_r   <= ext_pin;
      pin_lvl_r <= ext_pin;
    end
  end

  // per-source flag: source set wins over software or service clear
  genvar s;
  generate
    for (s = 0; s < NSRC; s++)
    begin : g_req
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          req_r[s] <= 1'b0;
        else if (clk_en)
        begin
          if (src_set[s])
            req_r[s] <= 1'b1;
          else if (sw_wr[s])
            req_r[s] <= rf.wdata[REQ_BIT];
          else if (accept && grant[s])
            req_r[s] <= 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // enable flags and watch interval select
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ena_r  <= NIB_RST;
      wsel_r <= 1'b0;
    end
    else if (clk_en)
    begin
      if (rf.wr && rf.addr == ENABLE_OFS)
        ena_r <= rf.wdata;
      if (rf.wr && rf.addr == WATCH_SEL_OFS)
        wsel_r <= rf.wdata[WATCH_SEL_BIT];
    end
  end

  // ----------------------------------------------------------------
  // master enable and enable-interrupts delay
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      master_enable_flag_r <= 1'b0;
      enable_op_dly_r      <= 1'b0;
    end
    else if (clk_en && cpu.cyc_end)
    begin
      if (accept)
        master_enable_flag_r <= 1'b0;
      else if (cpu.mask_all_op)
        master_enable_flag_r <= 1'b0;
      else if (cpu.enable_interrupts_op)
        master_enable_flag_r <= 1'b1;
      enable_op_dly_r <= cpu.enable_interrupts_op;
    end
  end

  // ----------------------------------------------------------------
  // table-read sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      seq_r <= ST_RUN;
    else if (clk_en && cpu.cyc_end)
    begin
      case (seq_r)
        ST_RUN:
          if (cpu.table_read_op)
            seq_r <= ST_TBL2;
        ST_TBL2:
          seq_r <= ST_RUN;
        default:
          seq_r <= ST_RUN;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // acceptance decision
  // ----------------------------------------------------------------
  assign eligible = req_r & ena_r;
  assign boundary = cpu.cyc_end &&
                    !(seq_r == ST_RUN && cpu.table_read_op);
  assign accept   = any_req && boundary && master_enable_flag_r
                    && !enable_op_dly_r && !cpu.return_from_handler_op
                    && !cpu.mask_all_op;
  assign ret      = cpu.cyc_end && cpu.return_from_handler_op;
  assign stack_ptr_dec = stack_pointer_r - 3'h1;

  fsiu_prio u_prio (
    .eligible (eligible),
    .any      (any_req),
    .grant    (grant)
  );

  // vector by granted source
  always_comb
  begin
    vec = VEC_SERIAL;
    if (grant[SRC_TIMER])
      vec = VEC_TIMER;
    else if (grant[SRC_EXT])
      vec = VEC_EXT;
    else if (grant[SRC_WATCH])
      vec = VEC_WATCH;
  end

  // ----------------------------------------------------------------
  // stacks
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stack_pointer_r <= PTR_RST;
    end
    else if (clk_en)
    begin
      if (accept)
      begin
        stack_pointer_r <= stack_ptr_dec;
      end
      else if (ret)
      begin
        stack_pointer_r <= stack_pointer_r + 3'h1;
      end
    end
  end

  // address stack entry picked by decremented pointer
  always_ff @(posedge clk)
  begin
    if (clk_en && accept)
      address_stack[stack_ptr_dec] <= cpu.branch_op ? cpu.branch_target : cpu.pc;
  end

  // three-level shift stack of bank and status flags
  always_ff @(posedge clk)
  begin
    if (clk_en && accept)
    begin
      handler_status_stack[0] <= {cpu.bank, cpu.psw};
      handler_status_stack[1] <= handler_status_stack[0];
      handler_status_stack[2] <= handler_status_stack[1];
    end
    else if (clk_en && ret)
    begin
      handler_status_stack[0] <= handler_status_stack[1];
      handler_status_stack[1] <= handler_status_stack[2];
    end
  end

  // ----------------------------------------------------------------
  // control to the sequencer, one cycle after the deciding edge
  // ----------------------------------------------------------------
  always_comb
  begin
    ctl_nxt        = '0;
    ctl_nxt.accept = accept;
    if (accept)
    begin
      ctl_nxt.load = 1'b1;
      ctl_nxt.pc   = vec;
    end
    else if (ret)
    begin
      ctl_nxt.load      = 1'b1;
      ctl_nxt.pc        = address_stack[stack_pointer_r];
      ctl_nxt.psw_load  = 1'b1;
      ctl_nxt.psw       = handler_status_stack[0][PSW_W-1:0];
      ctl_nxt.bank_load = 1'b1;
      ctl_nxt.bank      = handler_status_stack[0][BANK_W+PSW_W-1:PSW_W];
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ctl <= '0;
    else if (clk_en)
      ctl <= ctl_nxt;
  end

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  always_comb
  begin
    rdata_nxt = NIB_RST;
    if (rf.addr == SERIAL_REQ_OFS)
      rdata_nxt[REQ_BIT] = req_r[SRC_SERIAL];
    else if (rf.addr == TIMER_REQ_OFS)
      rdata_nxt[REQ_BIT] = req_r[SRC_TIMER];
    else if (rf.addr == WATCH_REQ_OFS)
      rdata_nxt[REQ_BIT] = req_r[SRC_WATCH];
    else if (rf.addr == EXT_REQ_OFS)
      rdata_nxt[REQ_BIT] = req_r[SRC_EXT];
    else if (rf.addr == ENABLE_OFS)
      rdata_nxt = ena_r;
    else if (rf.addr == PIN_LVL_OFS)
      rdata_nxt[PIN_LVL_BIT] = pin_lvl_r;
    else if (rf.addr == WATCH_SEL_OFS)
      rdata_nxt[WATCH_SEL_BIT] = wsel_r;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rf_rdata              <= NIB_RST;
      watch_interval_select <= 1'b0;
    end
    else if (clk_en)
    begin
      if (rf.rd)
        rf_rdata <= rdata_nxt;
      watch_interval_select <= wsel_r;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  timer_first_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && accept && req_r[SRC_TIMER] && ena_r[SRC_TIMER]
    |=> ctl.pc == VEC_TIMER)
    else $error("timer not given priority");
  no_accept_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    !master_enable_flag_r |-> !accept)
    else $error("accepted while master enable clear");
  ei_delay_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && cpu.cyc_end && enable_op_dly_r |-> !accept)
    else $error("accepted right after enable");
  clear_service_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && accept && grant[SRC_SERIAL] && !src_set[SRC_SERIAL] && !sw_wr[SRC_SERIAL]
    |=> !req_r[SRC_SERIAL])
    else $error("serviced flag not cleared");
  disabled_block_a: assert property (@(posedge clk) disable iff (!rst_n)
    accept |-> (req_r & ena_r) != 4'h0)
    else $error("accepted without enabled request");
  edge_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && ext_pin && !pin_d_r |=> req_r[SRC_EXT])
    else $error("pin edge lost");
  accept_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && accept |=> !master_enable_flag_r ##1 !accept)
    else $error("master enable kept after accept");
  table_defer_a: assert property (@(posedge clk) disable iff (!rst_n)
    seq_r == ST_RUN && cpu.table_read_op |-> !accept)
    else $error("accepted mid table read");
  sp_push_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && accept |=> stack_pointer_r == $past(stack_pointer_r) - 3'h1)
    else $error("pointer not decremented");
endmodule
`default_nettype wire

/* File: dv/fsiu_seq_model.sv */
`timescale 1ns/1ns
`default_nettype none
module fsiu_seq_model
  import fsiu_pkg::*;
#(
  parameter int CYC = 4
)
(
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic [4:0]          op,
  input  wire fsiu_pkg::fsiu_ctl_t ctl,
  output var  fsiu_pkg::fsiu_cpu_t cpu
);
  import fsiu_pkg::*;

  // ----------------------------------------------------------------
  // sequencer model
  // ----------------------------------------------------------------
  localparam logic [PC_W-1:0] BR_TGT = 12'h5A5;
  logic [3:0]      cnt_r;
  logic [PC_W-1:0] pc_r;

  // instruction cycle counter, last clock marks the cycle end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_r <= 4'h0;
    else
      cnt_r <= (cnt_r == 4'(CYC - 1)) ? 4'h0 : cnt_r + 4'h1;
  end

  // program counter: vector or return load overrides the normal step
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pc_r <= 12'h100;
    else if (ctl.load)
      pc_r <= ctl.pc;
    else if (cpu.cyc_end)
      pc_r <= op[0] ? BR_TGT : pc_r + 12'h001;
  end

  // status values follow the pc so each save is distinct
  always_comb
  begin
    cpu = '0;
    cpu.cyc_end = (cnt_r == 4'(CYC - 1));
    cpu.table_read_op = op[4];
    cpu.enable_interrupts_op = op[3];
    cpu.mask_all_op = op[2];
    cpu.return_from_handler_op = op[1];
    cpu.branch_op = op[0];
    cpu.branch_target = BR_TGT;
    cpu.pc = pc_r;
    cpu.bank = pc_r[3:0];
    cpu.psw = pc_r[4:0] ^ 5'h15;
  end
endmodule
`default_nettype wire

/* File: dv/fsiu_top_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module fsiu_top_tb;
  import fsiu_pkg::*;

  // ----------------------------------------------------------------
  // stimulus and observation
  // ----------------------------------------------------------------
  localparam logic [4:0] NOP = 5'h00;
  localparam logic [4:0] BRN = 5'h01;
  localparam logic [4:0] RET = 5'h02;
  localparam logic [4:0] DIS = 5'h04;
  localparam logic [4:0] ENA = 5'h08;
  localparam logic [4:0] TBL = 5'h10;
  logic        clk;
  logic        rst_n;
  logic        clk_en;
  logic [4:0]  opc;
  logic        ext_pin;
  logic [2:0]  src;
  logic [3:0]  rf_rdata;
  logic        wsel;
  fsiu_rf_t    rf;
  fsiu_cpu_t   cpu;
  fsiu_ctl_t   ctl;
  int          miscompares;
  int          compares;
  logic [20:0] saved[$];
  logic [6:0]  ofs[5];

  fsiu_top dut_u (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .cpu(cpu), .rf(rf),
    .ext_pin(ext_pin), .timer_match(src[0]), .watch_req(src[1]), .serial_done(src[2]),
    .rf_rdata(rf_rdata), .ctl(ctl), .watch_interval_select(wsel));

  fsiu_seq_model #(.CYC(4)) seq_u (.clk(clk), .rst_n(rst_n), .op(opc), .ctl(ctl), .cpu(cpu));

  // free running clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [20:0] exp, input logic [20:0] got);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic final_report;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic rf_wr(input logic [6:0] a, input logic [3:0] d);
    rf <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    rf.wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rf_rd(input logic [6:0] a, input logic [3:0] e, input string what);
    rf <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 4'h0};
    @(posedge clk);
    rf.rd <= 1'b0;
    @(posedge clk);
    chk(what, 21'(e), 21'(rf_rdata));
  endtask

  task automatic pulse(input logic [2:0] s);
    src <= s;
    @(posedge clk);
    src <= 3'h0;
    @(posedge clk);
  endtask

  // one instruction; the answer is looked at one clock after its end
  task automatic step(input logic [4:0] op, input logic acc, input logic [11:0] vec);
    int          n;
    logic [20:0] top;
    opc <= op;
    n = 0;
    @(posedge clk);
    while (cpu.cyc_end !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 20)
    begin
      miscompares++;
      final_report();
    end
    if (acc)
      saved.push_back({cpu.bank, cpu.psw, cpu.branch_op ? cpu.branch_target : cpu.pc});
    opc <= NOP;
    @(posedge clk);
    chk("accept", 21'(acc), 21'(ctl.accept));
    if (acc)
      chk("vector", 21'(vec), 21'(ctl.pc));
    if (op == RET)
    begin
      top = saved.pop_back();
      chk("restore strobes", 21'h7, 21'({ctl.load, ctl.psw_load, ctl.bank_load}));
      chk("restored state", top, {ctl.bank, ctl.psw, ctl.pc});
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    opc = NOP;
    ext_pin = 1'b0;
    src = 3'h0;
    rf = '0;
    miscompares = 0;
    compares = 0;
    ofs = '{SERIAL_REQ_OFS, TIMER_REQ_OFS, WATCH_REQ_OFS, EXT_REQ_OFS, ENABLE_OFS};
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (ofs[i]) rf_rd(ofs[i], 4'h0, "reset value");
    rf_rd(7'h50, 4'h0, "unmapped read");
    $display("test reset values done");
    ext_pin <= 1'b1;
    repeat (4) @(posedge clk);
    rf_rd(PIN_LVL_OFS, 4'h1, "pin level");
    rf_rd(EXT_REQ_OFS, 4'h8, "edge flag");
    rf_wr(EXT_REQ_OFS, 4'h0);
    rf_rd(EXT_REQ_OFS, 4'h0, "cancelled flag");
    rf_wr(TIMER_REQ_OFS, 4'h8);
    rf_rd(TIMER_REQ_OFS, 4'h8, "software raise");
    rf_wr(TIMER_REQ_OFS, 4'h0);
    rf_wr(WATCH_SEL_OFS, 4'h4);
    @(posedge clk);
    chk("interval select", 21'h1, 21'(wsel));
    ext_pin <= 1'b0;
    repeat (4) @(posedge clk);
    rf_rd(PIN_LVL_OFS, 4'h0, "pin level low");
    ext_pin <= 1'b1;
    repeat (4) @(posedge clk);
    clk_en <= 1'b0;
    pulse(3'h1);
    clk_en <= 1'b1;
    rf_rd(TIMER_REQ_OFS, 4'h0, "frozen flag");
    pulse(3'h7);
    rf_rd(TIMER_REQ_OFS, 4'h8, "timer flag");
    rf_rd(WATCH_REQ_OFS, 4'h8, "watch flag");
    rf_rd(SERIAL_REQ_OFS, 4'h8, "serial flag");
    $display("test sources done");
    step(NOP, 1'b0, 12'h000);
    step(ENA, 1'b0, 12'h000);
    step(NOP, 1'b0, 12'h000);
    step(NOP, 1'b0, 12'h000);
    rf_wr(ENABLE_OFS, 4'hF);
    step(NOP, 1'b1, VEC_TIMER);
    rf_rd(TIMER_REQ_OFS, 4'h0, "serviced flag");
    rf_rd(WATCH_REQ_OFS, 4'h8, "still pending");
    step(NOP, 1'b0, 12'h000);
    step(ENA, 1'b0, 12'h000);
    step(NOP, 1'b0, 12'h000);
    step(BRN, 1'b1, VEC_EXT);
    step(ENA, 1'b0, 12'h000);
    step(DIS, 1'b0, 12'h000);
    step(NOP, 1'b0, 12'h000);
    $display("test acceptance done");
    step(ENA, 1'b0, 12'h000);
    step(NOP, 1'b0, 12'h000);
    step(TBL, 1'b0, 12'h000);
    step(TBL, 1'b1, VEC_WATCH);
    step(ENA, 1'b0, 12'h000);
    step(RET, 1'b0, 12'h000);
    step(NOP, 1'b1, VEC_SERIAL);
    step(RET, 1'b0, 12'h000);
    step(RET, 1'b0, 12'h000);
    step(RET, 1'b0, 12'h000);
    $display("test return done");
    final_report();
  end
endmodule
`default_nettype wire
